/* verilog/wdcp_window.sv */
//----------------------------------------------------------------------
// Purpose : constants for the watchdog configuration protection block,
//           and the unlock window timer that it instantiates
// Assumes : one clock, ref_clk at 250 MHz, asynchronous active-low reset
// Notes   : the window counts system clock cycles, not watchdog cycles
//----------------------------------------------------------------------
// How it works
// - level 0: starts off, free enable, free timeout
// - level 1: starts off, enable by plain write
// - level 1: timeout change, disable need sequence
// - level 1: second write within four applies
// - level 2: always on, on bit reads one
// - level 2: timeout change only through sequence
// - level 2: second write sets timeout, ignores on
// - unlock bit clears four cycles after set
// - two fuses select the safety level
// - timeout select picks 16K to 2048K cycles
`timescale 1ns/1ps

package wdcp_pkg;
   //----------------------------------------------------------------
   // register map and bus widths
   //----------------------------------------------------------------
   localparam int ADDR_W            = 4;
   localparam int DATA_W            = 8;
   localparam logic [3:0] CTRL_OFS  = 4'h0;    // control: unlock, on, timeout
   localparam logic [3:0] STAT_OFS  = 4'h1;    // sticky events, write one to clear
   localparam logic [3:0] MASK_OFS  = 4'h2;    // interrupt mask
   localparam logic [3:0] LEVEL_OFS = 4'h3;    // safety level, read only

   //----------------------------------------------------------------
   // control field positions
   //----------------------------------------------------------------
   localparam int UNLOCK_BIT = 4;              // change unlock bit
   localparam int ON_BIT     = 3;              // watchdog on bit
   localparam int TSEL_LSB   = 0;              // timeout select low bit
   localparam int TSEL_W     = 3;              // timeout select width

   //----------------------------------------------------------------
   // event bit positions in status and mask
   //----------------------------------------------------------------
   localparam int EV_N      = 4;
   localparam int EV_OPEN   = 0;               // unlock window opened
   localparam int EV_APPLY  = 1;               // protected change applied
   localparam int EV_REFUSE = 2;               // protected change refused
   localparam int EV_EXPIRE = 3;               // window closed unused

   //----------------------------------------------------------------
   // reset values and timing
   //----------------------------------------------------------------
   localparam logic [2:0]  TSEL_RST          = 3'h0;
   localparam logic [3:0]  MASK_RST          = 4'h0;
   localparam logic [3:0]  STAT_RST          = 4'h0;
   localparam logic [2:0]  UNLOCK_WINDOW_CYC = 3'h4;      // cycles unlock stays set
   localparam logic [21:0] TIMEOUT_BASE      = 22'h004000; // 16K watchdog cycles

   //----------------------------------------------------------------
   // safety levels, one-hot
   //----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      WDCP_LVL0 = 3'b001,
      WDCP_LVL1 = 3'b010,
      WDCP_LVL2 = 3'b100
   } wdcp_level_t;
endpackage

//----------------------------------------------------------------------
// unlock window timer
//----------------------------------------------------------------------
module wdcp_window
   import wdcp_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic open_req,      // opening write seen this cycle
   input  wire logic close_req,     // window consumed this cycle
   output logic      window_open,   // unlock bit as software sees it
   output logic      expired        // pulse: window ran out unused
);
   logic [2:0] cnt_reg;             // cycles left in the window

   // reload on open, drop on use, else count down to zero
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_reg <= 3'h0;
      end
      else if (open_req)
      begin
         cnt_reg <= UNLOCK_WINDOW_CYC;
      end
      else if (close_req)
      begin
         cnt_reg <= 3'h0;
      end
      else if (cnt_reg != 3'h0)
      begin
         cnt_reg <= cnt_reg - 3'h1;
      end
   end

   assign window_open = (cnt_reg != 3'h0);
   assign expired     = (cnt_reg == 3'h1) && !open_req && !close_req;
endmodule

/* verilog/wdcp_core.sv */
//----------------------------------------------------------------------
// Purpose : write protection of watchdog enable and timeout settings
// Assumes : fuses are static levels from outside the clock domain
// Notes   : fuse inputs are 1 when programmed; level settles 2 cycles
//           after reset release
//----------------------------------------------------------------------
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps

module wdcp_core
   import wdcp_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        legacy_compat_fuse,
   input  wire logic        wd_always_on_fuse,
   output logic             wd_enable,
   output logic      [2:0]  wd_timeout_select,
   output logic      [21:0] wd_timeout_cycles,
   output logic             irq
);
   //----------------------------------------------------------------
   // declarations
   //----------------------------------------------------------------
   logic [1:0]       fuse_meta_reg;     // first synchroniser stage
   logic [1:0]       fuse_sync_reg;     // {compat, always_on}, safe to read
   wdcp_level_t      level;             // decoded safety level
   logic [1:0]       level_num;         // level as a small number
   logic             ctrl_wr;           // write to control register
   logic             stat_wr;           // write to status register
   logic             mask_wr;           // write to mask register
   logic             wr_unlock;         // unlock bit of write data
   logic             wr_on;             // on bit of write data
   logic [2:0]       wr_tsel;           // timeout select of write data
   logic             open_req;          // opening write of the sequence
   logic             commit;            // second write inside the window
   logic             window_open;       // unlock bit state
   logic             expired;           // window ran out
   logic             refuse;            // protected change dropped
   logic             wd_on_reg;         // effective watchdog on
   logic             wd_on_next;
   logic [2:0]       tsel_reg;          // timeout select
   logic [2:0]       tsel_next;
   logic [21:0]      tcyc_reg;          // timeout in watchdog cycles
   logic [EV_N-1:0]  ev;                // event pulses
   logic [EV_N-1:0]  stat_reg;          // sticky event bits
   logic [EV_N-1:0]  mask_reg;          // interrupt enables
   logic [7:0]       rdata_reg;         // read data, one cycle late

   //----------------------------------------------------------------
   // fuse synchroniser and safety level
   //----------------------------------------------------------------
   // two flops before anything looks at the fuses
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fuse_meta_reg <= 2'h0;
         fuse_sync_reg <= 2'h0;
      end
      else
      begin
         fuse_meta_reg <= {legacy_compat_fuse, wd_always_on_fuse};
         fuse_sync_reg <= fuse_meta_reg;
      end
   end

   // always-on wins; compat alone gives the legacy level
   always_comb
   begin
      if (fuse_sync_reg[0])
      begin
         level     = WDCP_LVL2;
         level_num = 2'h2;
      end
      else if (fuse_sync_reg[1])
      begin
         level     = WDCP_LVL0;
         level_num = 2'h0;
      end
      else
      begin
         level     = WDCP_LVL1;
         level_num = 2'h1;
      end
   end

   //----------------------------------------------------------------
   // write decode
   //----------------------------------------------------------------
   assign ctrl_wr   = reg_wr && (reg_addr == CTRL_OFS);
   assign stat_wr   = reg_wr && (reg_addr == STAT_OFS);
   assign mask_wr   = reg_wr && (reg_addr == MASK_OFS);
   assign wr_unlock = reg_wdata[UNLOCK_BIT];
   assign wr_on     = reg_wdata[ON_BIT];
   assign wr_tsel   = reg_wdata[TSEL_LSB +: TSEL_W];

   // opening write must carry unlock and on together
   assign open_req  = ctrl_wr && wr_unlock && wr_on;
   // second write: inside the window with unlock cleared
   assign commit    = ctrl_wr && window_open && !wr_unlock;

   //----------------------------------------------------------------
   // unlock window
   //----------------------------------------------------------------
   wdcp_window u_window
   (
      .ref_clk     (ref_clk),
      .arst_n      (arst_n),
      .open_req    (open_req),
      .close_req   (commit),
      .window_open (window_open),
      .expired     (expired)
   );

   //----------------------------------------------------------------
   // protected settings, next values
   //----------------------------------------------------------------
   always_comb
   begin
      wd_on_next = wd_on_reg;
      tsel_next  = tsel_reg;
      refuse     = 1'b0;
      if (ctrl_wr)
      begin
         unique case (level)
            WDCP_LVL0:
            begin
               tsel_next = wr_tsel;
               if (wr_on)
               begin
                  wd_on_next = 1'b1;
               end
               else if (commit)
               begin
                  wd_on_next = 1'b0;
               end
               else
               begin
                  refuse = wd_on_reg;
               end
            end
            WDCP_LVL1:
            begin
               if (commit)
               begin
                  wd_on_next = wr_on;
                  tsel_next  = wr_tsel;
               end
               else
               begin
                  if (wr_on)
                  begin
                     wd_on_next = 1'b1;
                  end
                  // disable or timeout change outside the sequence
                  refuse = (!wr_on && wd_on_reg) ||
                           (!open_req && (wr_tsel != tsel_reg));
               end
            end
            WDCP_LVL2:
            begin
               if (commit)
               begin
                  tsel_next = wr_tsel;
               end
               else
               begin
                  refuse = !open_req && (wr_tsel != tsel_reg);
               end
            end
         endcase
      end
      // level 2 holds the watchdog on whatever is written
      if (level == WDCP_LVL2)
      begin
         wd_on_next = 1'b1;
      end
   end

   // settings and timeout length update
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wd_on_reg <= 1'b0;
         tsel_reg  <= TSEL_RST;
         tcyc_reg  <= TIMEOUT_BASE;
      end
      else
      begin
         wd_on_reg <= wd_on_next;
         tsel_reg  <= tsel_next;
         tcyc_reg  <= TIMEOUT_BASE << tsel_next;
      end
   end

   //----------------------------------------------------------------
   // events, status and mask
   //----------------------------------------------------------------
   assign ev[EV_OPEN]   = open_req;
   assign ev[EV_APPLY]  = commit;
   assign ev[EV_REFUSE] = refuse;
   assign ev[EV_EXPIRE] = expired;

   // sticky bits; a new event beats a clear in the same cycle
   for (genvar i = 0; i < EV_N; i++)
   begin : g_stat
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            stat_reg[i] <= STAT_RST[i];
         end
         else
         begin
            stat_reg[i] <= ev[i] || (stat_reg[i] && !(stat_wr && reg_wdata[i]));
         end
      end
   end

   // mask register
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mask_reg <= MASK_RST;
      end
      else if (mask_wr)
      begin
         mask_reg <= reg_wdata[EV_N-1:0];
      end
   end

   //----------------------------------------------------------------
   // read port: data stands only in the cycle after the strobe
   //----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_reg <= 8'h00;
      end
      else if (reg_rd)
      begin
         unique case (reg_addr)
            CTRL_OFS  : rdata_reg <= {3'h0, window_open, wd_on_reg, tsel_reg};
            STAT_OFS  : rdata_reg <= {4'h0, stat_reg};
            MASK_OFS  : rdata_reg <= {4'h0, mask_reg};
            LEVEL_OFS : rdata_reg <= {6'h00, level_num};
            default   : rdata_reg <= 8'h00;   // unmapped reads zero
         endcase
      end
      else
      begin
         rdata_reg <= 8'h00;
      end
   end

   //----------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------
   assign reg_rdata         = rdata_reg;
   assign wd_enable         = wd_on_reg;
   assign wd_timeout_select = tsel_reg;
   assign wd_timeout_cycles = tcyc_reg;
   assign irq               = |(stat_reg & mask_reg);

   //----------------------------------------------------------------
   // assertions
   //----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_open;
      open_req;
   endsequence

   sequence s_quiet4;
      !ctrl_wr [*4];
   endsequence

   chk_window_opens: assert property (s_open |=> window_open)
      else $error("unlock bit not set after opening write");

   chk_window_closes: assert property (s_open ##1 s_quiet4 |=> !window_open)
      else $error("unlock bit still set after four cycles");

   chk_lvl2_forced_on: assert property (level == WDCP_LVL2 |=> wd_on_reg)
      else $error("watchdog off at level 2");

   chk_lvl1_commit_applies: assert property
      (level == WDCP_LVL1 && commit |=> wd_on_reg == $past(wr_on) &&
       tsel_reg == $past(wr_tsel))
      else $error("second write not applied at level 1");

   chk_lvl1_protected: assert property
      (level == WDCP_LVL1 && ctrl_wr && !commit |=> $stable(tsel_reg) &&
       (wd_on_reg || !$past(wd_on_reg)))
      else $error("protected change taken outside the window");

   chk_lvl1_free_enable: assert property
      (level == WDCP_LVL1 && ctrl_wr && wr_on |=> wd_on_reg)
      else $error("plain enable ignored at level 1");

   chk_lvl0_free_timeout: assert property
      (level == WDCP_LVL0 && ctrl_wr |=> tsel_reg == $past(wr_tsel))
      else $error("timeout not written at level 0");

   chk_lvl2_tsel_guard: assert property
      (level == WDCP_LVL2 && ctrl_wr && !commit |=> $stable(tsel_reg))
      else $error("timeout changed outside sequence at level 2");

   chk_late_write_ignored: assert property
      (ctrl_wr && !window_open && !wr_unlock && level != WDCP_LVL0
       |=> $stable(tsel_reg))
      else $error("late second write changed timeout");

   chk_ctrl_reserved_zero: assert property
      (reg_rd && reg_addr == CTRL_OFS |=> reg_rdata[7:5] == 3'h0)
      else $error("reserved control bits not zero");

   chk_timeout_table: assert property
      (wd_timeout_cycles == (TIMEOUT_BASE << tsel_reg))
      else $error("timeout length does not match select");

   chk_fuse_level: assert property
      (fuse_sync_reg == 2'b10 |-> level == WDCP_LVL0)
      else $error("compat fuse alone did not give level 0");
endmodule

/* bench/wdcp_core_tb.sv */
//----------------------------------------------------------------------
// Purpose : self-checking bench for the watchdog configuration protection
// Assumes : fuses change only while reset is held; level settles after 2
// Notes   : each scenario drives the register port and judges the outputs
//----------------------------------------------------------------------
`timescale 1ns/1ps

module wdcp_core_tb
   import wdcp_pkg::*;
;
   //----------------------------------------------------------------
   // signals
   //----------------------------------------------------------------
   logic        ref_clk;              // system clock, 4 ns period
   logic        arst_n;               // asynchronous reset, active low
   logic [3:0]  reg_addr;             // register address
   logic [7:0]  reg_wdata;            // write data
   logic        reg_wr;               // write strobe
   logic        reg_rd;               // read strobe
   logic [7:0]  reg_rdata;            // read data, one cycle after strobe
   logic        legacy_compat_fuse;   // 1 = programmed
   logic        wd_always_on_fuse;    // 1 = programmed
   logic        wd_enable;            // watchdog on
   logic [2:0]  wd_timeout_select;    // timeout select
   logic [21:0] wd_timeout_cycles;    // timeout in watchdog cycles
   logic        irq;                  // level interrupt
   int          n_fail;               // mismatches seen
   int          checked;              // comparisons made

   wdcp_core dut
   (
      .ref_clk            (ref_clk),
      .arst_n             (arst_n),
      .reg_addr           (reg_addr),
      .reg_wdata          (reg_wdata),
      .reg_wr             (reg_wr),
      .reg_rd             (reg_rd),
      .reg_rdata          (reg_rdata),
      .legacy_compat_fuse (legacy_compat_fuse),
      .wd_always_on_fuse  (wd_always_on_fuse),
      .wd_enable          (wd_enable),
      .wd_timeout_select  (wd_timeout_select),
      .wd_timeout_cycles  (wd_timeout_cycles),
      .irq                (irq)
   );

   //----------------------------------------------------------------
   // clock generation
   //----------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   //----------------------------------------------------------------
   // checking and closing
   //----------------------------------------------------------------
   // compare one value, count it, report a mismatch at once
   task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
      begin
         checked++;
         if (seen !== exp)
         begin
            n_fail++;
            $display("[ERR] %0t value %h, wanted %h", $time, seen, exp);
         end
      end
   endtask

   // verdict and end of run
   task automatic end_sim;
      begin
         $display("checks %0d, mismatches %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   //----------------------------------------------------------------
   // bus and sequence helpers
   //----------------------------------------------------------------
   // one-cycle write; returns just after the sampling edge has landed
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      begin
         @(posedge ref_clk);
         reg_wr    <= 1'b1;
         reg_addr  <= a;
         reg_wdata <= d;
         @(posedge ref_clk);
         reg_wr    <= 1'b0;
         #1;
      end
   endtask

   // one-cycle read; data is taken in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      begin
         @(posedge ref_clk);
         reg_rd   <= 1'b1;
         reg_addr <= a;
         @(posedge ref_clk);
         reg_rd   <= 1'b0;
         #1;
         d = reg_rdata;
      end
   endtask

   // let n clock edges pass
   task automatic idle(input int n);
      begin
         repeat (n) @(posedge ref_clk);
      end
   endtask

   // reset with a fuse pair, then wait until the level has settled
   task automatic do_reset(input logic compat, input logic aon);
      begin
         @(posedge ref_clk);
         arst_n             <= 1'b0;
         legacy_compat_fuse <= compat;
         wd_always_on_fuse  <= aon;
         idle(16);
         arst_n <= 1'b1;
         idle(4);
         #1;
      end
   endtask

   // opening write, then the committing write two edges later
   task automatic unlock(input logic [7:0] commit);
      begin
         wr(CTRL_OFS, 8'h18);
         wr(CTRL_OFS, commit);
      end
   endtask

   // protected outputs against the wanted on bit and select
   task automatic check_out(input logic on, input logic [2:0] sel);
      begin
         chk(22'(wd_enable), 22'(on));
         chk(22'(wd_timeout_select), 22'(sel));
         chk(wd_timeout_cycles, TIMEOUT_BASE << sel);
      end
   endtask

   //----------------------------------------------------------------
   // scenarios
   //----------------------------------------------------------------
   // level 0: free enable and select, disable only by sequence
   task automatic scn_level0;
      logic [7:0] d;
      begin
         do_reset(1'b1, 1'b0);
         rd(LEVEL_OFS, d);
         chk(22'(d), 22'h0);
         check_out(1'b0, 3'h0);
         wr(CTRL_OFS, 8'h0D);
         check_out(1'b1, 3'h5);
         wr(CTRL_OFS, 8'h02);
         check_out(1'b1, 3'h2);
         unlock(8'h00);
         check_out(1'b0, 3'h0);
         wr(CTRL_OFS, 8'hE3);
         rd(CTRL_OFS, d);
         chk(22'(d), 22'h03);
         rd(4'h7, d);
         chk(22'(d), 22'h0);
      end
   endtask

   // level 1: enable free, disable and select by sequence, interrupt
   task automatic scn_level1;
      logic [7:0] d;
      int         s;
      begin
         do_reset(1'b0, 1'b0);
         rd(LEVEL_OFS, d);
         chk(22'(d), 22'h1);
         check_out(1'b0, 3'h0);
         wr(CTRL_OFS, 8'h0E);
         check_out(1'b1, 3'h0);
         wr(STAT_OFS, 8'h0F);
         wr(CTRL_OFS, 8'h00);
         check_out(1'b1, 3'h0);
         rd(STAT_OFS, d);
         chk(22'(d), 22'h04);
         chk(22'(irq), 22'h0);
         wr(MASK_OFS, 8'h04);
         chk(22'(irq), 22'h1);
         wr(STAT_OFS, 8'h04);
         chk(22'(irq), 22'h0);
         wr(MASK_OFS, 8'h00);
         unlock(8'h05);
         check_out(1'b0, 3'h5);
         // every select code through the sequence
         for (s = 0; s < 8; s++)
         begin
            unlock({5'b00001, 3'(s)});
            check_out(1'b1, 3'(s));
         end
         // commit with unlock still set is refused
         unlock(8'h13);
         check_out(1'b1, 3'h7);
         // commit after the window is refused
         wr(CTRL_OFS, 8'h18);
         idle(4);
         wr(CTRL_OFS, 8'h02);
         check_out(1'b1, 3'h7);
         // window seen open at edges 2 and 4, closed at 6
         wr(STAT_OFS, 8'h0F);
         wr(CTRL_OFS, 8'h18);
         rd(CTRL_OFS, d);
         chk(22'(d), 22'h1F);
         rd(CTRL_OFS, d);
         chk(22'(d), 22'h1F);
         rd(CTRL_OFS, d);
         chk(22'(d), 22'h0F);
         rd(STAT_OFS, d);
         chk(22'(d), 22'h09);
      end
   endtask

   // level 2: always on under both compat settings, select by sequence with compat set
   task automatic scn_level2;
      logic [7:0] d;
      int         f;
      begin
         for (f = 0; f < 2; f++)
         begin
            do_reset(1'(f), 1'b1);
            rd(LEVEL_OFS, d);
            chk(22'(d), 22'h2);
            chk(22'(wd_enable), 22'h1);
         end
         wr(CTRL_OFS, 8'h00);
         check_out(1'b1, 3'h0);
         rd(CTRL_OFS, d);
         chk(22'(d), 22'h08);
         wr(CTRL_OFS, 8'h05);
         check_out(1'b1, 3'h0);
         unlock(8'h03);
         check_out(1'b1, 3'h3);
         // refused select, then window opened and change applied
         rd(STAT_OFS, d);
         chk(22'(d), 22'h07);
      end
   endtask

   //----------------------------------------------------------------
   // main sequence and hang guard
   //----------------------------------------------------------------
   initial
   begin
      n_fail             = 0;
      checked            = 0;
      arst_n             = 1'b0;
      reg_addr           = 4'h0;
      reg_wdata          = 8'h00;
      reg_wr             = 1'b0;
      reg_rd             = 1'b0;
      legacy_compat_fuse = 1'b0;
      wd_always_on_fuse  = 1'b0;
      scn_level0;
      scn_level1;
      scn_level2;
      end_sim;
   end

   // cut a hang short as a mismatch
   initial
   begin
      idle(20000);
      n_fail++;
      $display("[ERR] %0t run took too long", $time);
      end_sim;
   end

endmodule
